// ===== core/dacl_pkg.sv
/*
 * constants, field layout, register map and latch target codes for the dual converter serial loader.
 * assumes a 50 MHz system clock and a serial link clock of its own from the host.
 */
// Functional notes
// - with select low, shift one data bit per falling serial clock edge, msb first
// - after sixteen bits or a select rise, move the word into the chosen latches
// - frame is 16 bits: four program bits on top, twelve value bits below
// - speed bit one gives fast mode, zero gives slow mode
// - power bit one enters power-down, zero returns to normal; other bits ignored
// - speed and power bits clear to zero at power up
// - reset clears both output latches and the holding buffer
// - selects 00 load output b and the holding buffer
// - selects 01 load the holding buffer only; selects 11 are reserved
// - selects 10 load output a and copy the holding buffer to output b
// - the twelve value bits become the new converter code of the target
// - update happens at the first rising serial clock edge after the sixteenth falling edge; the latches here load a few clock_in cycles later
// - output a and output b change together on a select-high write
// - select is active low; while high, clock and data are ignored
package dacl_pkg;

   localparam int WORD_W = 16;
   localparam int CODE_W = 12;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;

   // ---------------------------------------------------------------
   // field positions of the serial word
   // ---------------------------------------------------------------
   localparam int POS_SEL_HIGH = 15;
   localparam int POS_SPEED = 14;
   localparam int POS_POWER = 13;
   localparam int POS_SEL_LOW = 12;
   localparam int POS_CODE_LSB = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [CODE_W-1:0] RST_CODE = 12'h000;
   localparam logic RST_SPEED = 1'b0;
   localparam logic RST_POWER = 1'b0;
   localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;

   // ---------------------------------------------------------------
   // register map, byte addresses
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BUFFER = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_INJECT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FRAMES = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_LAST_WORD = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_RESERVED = 8'h1c;
   localparam int STAT_SPEED = 0;
   localparam int STAT_POWER = 1;
   localparam int STAT_ACTIVE = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // latch targets of a word
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      TGT_B_BUF = 5'h01,
      TGT_BUF = 5'h02,
      TGT_A_COPY = 5'h04,
      TGT_RSVD = 5'h08,
      TGT_POWER = 5'h10
   } dacl_target_e;

endpackage

// ===== core/dacl_sync.sv
/*
 * two flip-flop level synchroniser, one lane per bit.
 * assumes each input is a slow level from another clock domain.
 */
`timescale 1ns/1ps
module dacl_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
      end else begin
         stage1_q <= async_in;
         stage2_q <= stage1_q;
      end
   end

   assign sync_out = stage2_q;
endmodule

// ===== core/dacl_link_rx.sv
/*
 * serial link receiver on the host's serial clock.
 * assumes the serial clock runs only while select is low; select high resets the bit counter.
 */
`timescale 1ns/1ps
module dacl_link_rx
   import dacl_pkg::*;
(
   input wire logic serial_clock_in,
   input wire logic reset_n_in,
   input wire logic chip_select_n_in,
   input wire logic serial_data_in,
   output logic [dacl_pkg::WORD_W-1:0] shift_out,
   output logic [dacl_pkg::WORD_W-1:0] word_out,
   output logic done_toggle_out
);
   logic link_rst_n;
   logic [CNT_W-1:0] count_q, count_d;
   logic [WORD_W-1:0] shift_q, shift_d;
   logic fired_q, fired_d;
   logic [WORD_W-1:0] word_q, word_d;
   logic toggle_q, toggle_d;

   // counter and fired flag restart whenever select is high
   assign link_rst_n = reset_n_in & ~chip_select_n_in;

   // ---------------------------------------------------------------
   // falling edge capture
   // ---------------------------------------------------------------
   always_comb begin
      count_d = count_q;
      shift_d = shift_q;
      if (count_q != FRAME_BITS && !chip_select_n_in) begin
         count_d = count_q + 5'h01;
         shift_d = {shift_q[WORD_W-2:0], serial_data_in};
      end
   end

   always_ff @(negedge serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(negedge serial_clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         shift_q <= RST_WORD;
      end else begin
         shift_q <= shift_d;
      end
   end

   // ---------------------------------------------------------------
   // rising edge after the sixteenth bit
   // ---------------------------------------------------------------
   always_comb begin
      fired_d = fired_q;
      word_d = word_q;
      toggle_d = toggle_q;
      if (count_q == FRAME_BITS && !fired_q) begin
         fired_d = 1'b1;
         word_d = shift_q;
         toggle_d = ~toggle_q;
      end
   end

   always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fired_q <= 1'b0;
      end else begin
         fired_q <= fired_d;
      end
   end

   always_ff @(posedge serial_clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         word_q <= RST_WORD;
         toggle_q <= 1'b0;
      end else begin
         word_q <= word_d;
         toggle_q <= toggle_d;
      end
   end

   assign shift_out = shift_q;
   assign word_out = word_q;
   assign done_toggle_out = toggle_q;
endmodule

// ===== core/dacl_top.sv
/*
 * dual converter serial loader: link receiver, domain crossing, latches and axi4-lite slave.
 * assumes the host keeps select low across a whole frame and sends no reserved select code.
 */
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module dacl_top (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic serial_clock_in,
   input wire logic chip_select_n_in,
   input wire logic serial_data_in,
   output logic [dacl_pkg::CODE_W-1:0] output_a_out,
   output logic [dacl_pkg::CODE_W-1:0] output_b_out,
   output logic fast_mode_out,
   output logic power_down_out,
   input wire logic [dacl_pkg::ADDR_W-1:0] axi_awaddr_in,
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   output logic [1:0] axi_bresp_out,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   input wire logic [dacl_pkg::ADDR_W-1:0] axi_araddr_in,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in
);
   import dacl_pkg::*;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic dacl_target_e word_target(input logic [WORD_W-1:0] word);
      dacl_target_e tgt;
      tgt = TGT_RSVD;
      if (word[POS_POWER]) begin
         tgt = TGT_POWER;
      end else begin
         unique case ({word[POS_SEL_HIGH], word[POS_SEL_LOW]})
            2'b00: tgt = TGT_B_BUF;
            2'b01: tgt = TGT_BUF;
            2'b10: tgt = TGT_A_COPY;
            2'b11: tgt = TGT_RSVD;
         endcase
      end
      return tgt;
   endfunction

   function automatic logic [CODE_W-1:0] word_code(input logic [WORD_W-1:0] word);
      return word[POS_CODE_LSB +: CODE_W];
   endfunction

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      return addr[1:0] == 2'h0 && addr <= OFS_RESERVED;
   endfunction

   // ---------------------------------------------------------------
   // link domain
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] link_shift;
   logic [WORD_W-1:0] link_word;
   logic link_toggle;

   dacl_link_rx u_link_rx (
      .serial_clock_in(serial_clock_in),
      .reset_n_in(reset_n_in),
      .chip_select_n_in(chip_select_n_in),
      .serial_data_in(serial_data_in),
      .shift_out(link_shift),
      .word_out(link_word),
      .done_toggle_out(link_toggle)
   );

   // ---------------------------------------------------------------
   // crossing into the system clock
   // ---------------------------------------------------------------
   logic [1:0] sync_lvl;
   logic cs_s;
   logic tog_s;

   dacl_sync #(
      .WIDTH(2),
      .RESET_VAL(2'b10)
   ) u_sync (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .async_in({chip_select_n_in, link_toggle}),
      .sync_out(sync_lvl)
   );

   assign cs_s = sync_lvl[1];
   assign tog_s = sync_lvl[0];

   logic cs_hi_q, cs_hi_d;
   logic cs_hi2_q, cs_hi2_d;
   logic tog_q, tog_d;
   logic frame_done_q, frame_done_d;
   logic done_ev;
   logic cs_rise;
   logic cs_fall;
   logic partial_ev;

   // the select edge is seen one stage after the toggle so a full frame wins the race
   assign done_ev = tog_s ^ tog_q;
   assign cs_rise = cs_hi_q & ~cs_hi2_q;
   assign cs_fall = ~cs_hi_q & cs_hi2_q;
   assign partial_ev = cs_rise & ~frame_done_q & ~done_ev;

   always_comb begin
      cs_hi_d = cs_s;
      cs_hi2_d = cs_hi_q;
      tog_d = tog_s;
      frame_done_d = frame_done_q;
      if (cs_fall) begin
         frame_done_d = 1'b0;
      end
      if (done_ev) begin
         frame_done_d = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cs_hi_q <= 1'b1;
         cs_hi2_q <= 1'b1;
         tog_q <= 1'b0;
         frame_done_q <= 1'b0;
      end else begin
         cs_hi_q <= cs_hi_d;
         cs_hi2_q <= cs_hi2_d;
         tog_q <= tog_d;
         frame_done_q <= frame_done_d;
      end
   end

   // ---------------------------------------------------------------
   // axi write channel state
   // ---------------------------------------------------------------
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic aw_full_q, aw_full_d;
   logic w_full_q, w_full_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic serial_xfer;
   logic wr_exec;
   logic inject_ev;
   logic [31:0] wmask;

   assign serial_xfer = done_ev | partial_ev;
   // a serial transfer has priority; the bus write waits one cycle
   assign wr_exec = aw_full_q & w_full_q & ~bvalid_q & ~serial_xfer;
   assign inject_ev = wr_exec & (awaddr_q == OFS_INJECT);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wstrb_q[i]}};
      end
   end

   always_comb begin
      awready_d = awready_q;
      wready_d = wready_q;
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (axi_awvalid_in && awready_q) begin
         awready_d = 1'b0;
         aw_full_d = 1'b1;
         awaddr_d = axi_awaddr_in;
      end
      if (axi_wvalid_in && wready_q) begin
         wready_d = 1'b0;
         w_full_d = 1'b1;
         wdata_d = axi_wdata_in;
         wstrb_d = axi_wstrb_in;
      end
      if (wr_exec) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && axi_bready_in) begin
         bvalid_d = 1'b0;
         awready_d = 1'b1;
         wready_d = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // ---------------------------------------------------------------
   // converter latches
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] out_a_q, out_a_d;
   logic [CODE_W-1:0] out_b_q, out_b_d;
   logic [CODE_W-1:0] buf_q, buf_d;
   logic speed_q, speed_d;
   logic power_q, power_d;
   logic [WORD_W-1:0] last_word_q, last_word_d;
   logic [15:0] frames_q, frames_d;
   logic [15:0] rsvd_q, rsvd_d;
   logic apply;
   logic [WORD_W-1:0] apply_word;

   assign apply = serial_xfer | inject_ev;
   assign apply_word = done_ev ? link_word : (partial_ev ? link_shift : WORD_W'(wdata_q & wmask));

   always_comb begin
      out_a_d = out_a_q;
      out_b_d = out_b_q;
      buf_d = buf_q;
      speed_d = speed_q;
      power_d = power_q;
      last_word_d = last_word_q;
      frames_d = frames_q;
      rsvd_d = rsvd_q;
      if (apply) begin
         last_word_d = apply_word;
         frames_d = frames_q + 16'h0001;
         unique case (word_target(apply_word))
            TGT_POWER: begin
               power_d = 1'b1;
            end
            TGT_B_BUF: begin
               power_d = 1'b0;
               speed_d = apply_word[POS_SPEED];
               out_b_d = word_code(apply_word);
               buf_d = word_code(apply_word);
            end
            TGT_BUF: begin
               power_d = 1'b0;
               speed_d = apply_word[POS_SPEED];
               buf_d = word_code(apply_word);
            end
            TGT_A_COPY: begin
               power_d = 1'b0;
               speed_d = apply_word[POS_SPEED];
               out_a_d = word_code(apply_word);
               out_b_d = buf_q;
            end
            TGT_RSVD: begin
               power_d = 1'b0;
               speed_d = apply_word[POS_SPEED];
               rsvd_d = rsvd_q + 16'h0001;
            end
            default: begin
               rsvd_d = rsvd_q;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_a_q <= RST_CODE;
         out_b_q <= RST_CODE;
         buf_q <= RST_CODE;
         speed_q <= RST_SPEED;
         power_q <= RST_POWER;
         last_word_q <= RST_WORD;
         frames_q <= 16'h0000;
         rsvd_q <= 16'h0000;
      end else begin
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         buf_q <= buf_d;
         speed_q <= speed_d;
         power_q <= power_d;
         last_word_q <= last_word_d;
         frames_q <= frames_d;
         rsvd_q <= rsvd_d;
      end
   end

   // ---------------------------------------------------------------
   // axi read channel
   // ---------------------------------------------------------------
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rd_val;

   always_comb begin
      rd_val = 32'h00000000;
      unique case (axi_araddr_in)
         OFS_OUTPUT_A: rd_val[CODE_W-1:0] = out_a_q;
         OFS_OUTPUT_B: rd_val[CODE_W-1:0] = out_b_q;
         OFS_BUFFER: rd_val[CODE_W-1:0] = buf_q;
         OFS_STATUS: begin
            rd_val[STAT_SPEED] = speed_q;
            rd_val[STAT_POWER] = power_q;
            rd_val[STAT_ACTIVE] = ~cs_hi_q;
         end
         OFS_FRAMES: rd_val[15:0] = frames_q;
         OFS_LAST_WORD: rd_val[WORD_W-1:0] = last_word_q;
         OFS_RESERVED: rd_val[15:0] = rsvd_q;
         default: rd_val = 32'h00000000;
      endcase
   end

   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (axi_arvalid_in && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rdata_d = rd_val;
         rresp_d = reg_mapped(axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && axi_rready_in) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign output_a_out = out_a_q;
   assign output_b_out = out_b_q;
   assign fast_mode_out = speed_q;
   assign power_down_out = power_q;
   assign axi_awready_out = awready_q;
   assign axi_wready_out = wready_q;
   assign axi_bresp_out = bresp_q;
   assign axi_bvalid_out = bvalid_q;
   assign axi_arready_out = arready_q;
   assign axi_rdata_out = rdata_q;
   assign axi_rresp_out = rresp_q;
   assign axi_rvalid_out = rvalid_q;
endmodule

// ===== testbench/dacl_top_props.sv
/*
 * concurrent checks on the ports of the dual converter loader.
 * assumes it is bound into dacl_top and watches the clock_in domain.
 */
`timescale 1ns/1ps
module dacl_top_props
   import dacl_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic serial_clock_in,
   input wire logic chip_select_n_in,
   input wire logic [dacl_pkg::CODE_W-1:0] output_a_out,
   input wire logic [dacl_pkg::CODE_W-1:0] output_b_out,
   input wire logic fast_mode_out,
   input wire logic power_down_out,
   input wire logic axi_awvalid_in,
   input wire logic axi_awready_out,
   input wire logic axi_wvalid_in,
   input wire logic axi_wready_out,
   input wire logic axi_bvalid_out,
   input wire logic [1:0] axi_bresp_out,
   input wire logic axi_bready_in,
   input wire logic axi_arvalid_in,
   input wire logic axi_arready_out,
   input wire logic axi_rvalid_out,
   input wire logic [31:0] axi_rdata_out,
   input wire logic axi_rready_in
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // ----------------------------------------
   // cycles since any link activity or bus write address
   // ----------------------------------------
   logic sck_q, sel_q;
   logic [3:0] quiet_q, quiet_d;
   always_comb begin
      quiet_d = quiet_q;
      if ((serial_clock_in != sck_q && !sel_q) || chip_select_n_in != sel_q || axi_awvalid_in) quiet_d = 4'h0;
      else if (quiet_q != 4'hf) quiet_d = quiet_q + 4'h1;
   end
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sck_q <= 1'b1;
         sel_q <= 1'b1;
         quiet_q <= 4'h0;
      end else begin
         sck_q <= serial_clock_in;
         sel_q <= chip_select_n_in;
         quiet_q <= quiet_d;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_wr_taken;
      axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out;
   endsequence
   sequence s_rd_taken;
      axi_arvalid_in && axi_arready_out;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] axi_bvalid_out) else $error("no write response");
   AST_RD_ANSWER: assert property (s_rd_taken |=> axi_rvalid_out && !axi_arready_out) else $error("no read data");
   AST_B_STANDS: assert property (axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out && $stable(axi_bresp_out))
      else $error("write response dropped");
   AST_R_STANDS: assert property (axi_rvalid_out && !axi_rready_in |=> axi_rvalid_out && $stable(axi_rdata_out))
      else $error("read data dropped");
   AST_B_BLOCKS: assert property (axi_bvalid_out |-> !axi_awready_out && !axi_wready_out)
      else $error("ready during response");
   AST_QUIET: assert property (quiet_q >= 4'ha |-> $stable(output_a_out) && $stable(output_b_out) &&
      $stable(power_down_out) && $stable(fast_mode_out)) else $error("output moved without cause");
   AST_PD_KEEPS: assert property ($rose(power_down_out) |-> $stable(output_a_out) &&
      $stable(output_b_out) && $stable(fast_mode_out)) else $error("power-down word moved a latch");
   AST_LATCH_WAKES: assert property ($changed(output_a_out) || $changed(output_b_out) |-> !power_down_out)
      else $error("latch write left power-down set");
   AST_RESET_VAL: assert property (disable iff (1'b0) !reset_n_in |-> output_a_out == RST_CODE &&
      output_b_out == RST_CODE && fast_mode_out == RST_SPEED && power_down_out == RST_POWER)
      else $error("reset value wrong");
endmodule

bind dacl_top dacl_top_props u_props (.clock_in(clock_in), .reset_n_in(reset_n_in),
   .serial_clock_in(serial_clock_in), .chip_select_n_in(chip_select_n_in), .output_a_out(output_a_out),
   .output_b_out(output_b_out), .fast_mode_out(fast_mode_out), .power_down_out(power_down_out),
   .axi_awvalid_in(axi_awvalid_in), .axi_awready_out(axi_awready_out), .axi_wvalid_in(axi_wvalid_in),
   .axi_wready_out(axi_wready_out), .axi_bvalid_out(axi_bvalid_out), .axi_bresp_out(axi_bresp_out),
   .axi_bready_in(axi_bready_in), .axi_arvalid_in(axi_arvalid_in), .axi_arready_out(axi_arready_out),
   .axi_rvalid_out(axi_rvalid_out), .axi_rdata_out(axi_rdata_out), .axi_rready_in(axi_rready_in));

// ===== testbench/dacl_host_model.sv
/*
 * host serial port model: select, 64 ns serial clock, data msb first.
 * assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps
module dacl_host_model (
   output logic serial_clock_out,
   output logic chip_select_n_out,
   output logic serial_data_out
);
   initial begin
      serial_clock_out = 1'b1;
      chip_select_n_out = 1'b1;
      serial_data_out = 1'b0;
   end
   // ----------------------------------------
   // one frame, clock idle high outside it
   // ----------------------------------------
   task automatic send(input logic [15:0] w, input int nbits);
      #7 chip_select_n_out = 1'b0;
      #20;
      for (int i = 0; i < nbits; i++) begin
         serial_data_out = w[15-i];
         #32 serial_clock_out = 1'b0;
         #32 serial_clock_out = 1'b1;
         if (i == 7) #100;
      end
      #40 chip_select_n_out = 1'b1;
      serial_data_out = ~serial_data_out;
      #400;
   endtask
   // ----------------------------------------
   // clock and data wiggle with select high
   // ----------------------------------------
   task automatic noise();
      for (int i = 0; i < 8; i++) begin
         #32 serial_clock_out = ~serial_clock_out;
         serial_data_out = ~serial_data_out;
      end
      #400;
   endtask
endmodule

// ===== testbench/test_dual_dac_serial_loader.sv
/*
 * self-checking bench: serial frames through the host model, registers over axi4-lite.
 * assumes the package and all modules are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_dual_dac_serial_loader;
   import dacl_pkg::*;
   logic clk = 1'b0, rst_n, sck, sel_n, sdi;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fast, pd;
   logic [1:0] bresp, rresp;
   logic [CODE_W-1:0] out_a, out_b;
   int n_errors = 0, n_tests = 0;
   always #10 clk = ~clk;
   dacl_host_model HOST (.serial_clock_out(sck), .chip_select_n_out(sel_n), .serial_data_out(sdi));
   dacl_top DUT (.clock_in(clk), .reset_n_in(rst_n), .serial_clock_in(sck), .chip_select_n_in(sel_n),
      .serial_data_in(sdi), .output_a_out(out_a), .output_b_out(out_b), .fast_mode_out(fast),
      .power_down_out(pd), .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
      .axi_wdata_in(wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
      .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
      .axi_arvalid_in(arvalid), .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
      .axi_rvalid_out(rvalid), .axi_rready_in(rready));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      `CHK(bresp, er)
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ev, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      `CHK(rdata, ev)
      `CHK(rresp, er)
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic state(input logic [11:0] a, input logic [11:0] b, input logic [11:0] h, input logic f,
      input logic p);
      @(posedge clk);
      `CHK(out_a, a)
      `CHK(out_b, b)
      `CHK(fast, f)
      `CHK(pd, p)
      rd(OFS_BUFFER, {20'h0, h}, RESP_OKAY);
      rd(OFS_STATUS, {29'h0, 1'b0, p, f}, RESP_OKAY);
   endtask
   task automatic report_and_stop();
      $display("errors=%0d comparisons=%0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      state(12'h000, 12'h000, 12'h000, 1'b0, 1'b0);
      HOST.send(16'h4abc, 16);
      state(12'h000, 12'habc, 12'habc, 1'b1, 1'b0);
      HOST.send(16'h1123, 16);
      state(12'h000, 12'habc, 12'h123, 1'b0, 1'b0);
      HOST.send(16'h8456, 16);
      state(12'h456, 12'h123, 12'h123, 1'b0, 1'b0);
      HOST.send(16'hf5a5, 16);
      state(12'h456, 12'h123, 12'h123, 1'b0, 1'b1);
      rd(OFS_FRAMES, 32'h4, RESP_OKAY);
      HOST.send(16'h0012, 16);
      state(12'h456, 12'h012, 12'h012, 1'b0, 1'b0);
      HOST.noise();
      state(12'h456, 12'h012, 12'h012, 1'b0, 1'b0);
      rd(OFS_FRAMES, 32'h5, RESP_OKAY);
      HOST.send(16'h3400, 8);
      state(12'h456, 12'h012, 12'h234, 1'b0, 1'b0);
      rd(OFS_LAST_WORD, 32'h1234, RESP_OKAY);
      wr(OFS_INJECT, 32'h0000_cabc, RESP_OKAY);
      state(12'habc, 12'h234, 12'h234, 1'b1, 1'b0);
      wr(OFS_OUTPUT_A, 32'h0000_0555, RESP_OKAY);
      rd(OFS_OUTPUT_A, 32'h0000_0abc, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h24, 32'h0000_1111, RESP_SLVERR);
      rd(OFS_FRAMES, 32'h7, RESP_OKAY);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      state(12'h000, 12'h000, 12'h000, 1'b0, 1'b0);
      report_and_stop();
   end
endmodule
